// >>> design/rsfs_pkg.sv
// Package with constants and types for the reset source and flag sequencer.
package rsfs_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned RELEASE_DELAY_MS = 50;
    localparam int unsigned RELEASE_DELAY_CYC = RELEASE_DELAY_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned UV_FILTER_NS = 1000;
    localparam int unsigned UV_FILTER_CYC = (UV_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] STARTUP_WAIT_RC = 8'h02;
    localparam logic [7:0] STARTUP_WAIT_XTAL = 8'h80;
    localparam int unsigned CNT_W = 24;
    // ------------------------------------------------------------
    // APB register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
    // Control register fields.
    localparam int unsigned CTRL_UV_EN = 0;
    localparam int unsigned CTRL_UV_SEL = 1;
    localparam int unsigned CTRL_OSC = 3;
    localparam int unsigned CTRL_SLEEP = 5;
    localparam int unsigned CTRL_WAKE = 6;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    // Status register fields.
    localparam int unsigned STAT_TO = 0;
    localparam int unsigned STAT_PD = 1;
    localparam int unsigned STAT_CORE_RST = 2;
    localparam int unsigned STAT_LAST = 4;
    // Interrupt event bits.
    localparam int unsigned IRQ_PIN = 0;
    localparam int unsigned IRQ_UV = 1;
    localparam int unsigned IRQ_WDT = 2;
    localparam int unsigned IRQ_WAKE = 3;
    localparam int unsigned IRQ_N = 4;
    // Port and stack reset values.
    localparam logic [7:0] PORT_RESET = 8'hff;
    localparam logic [1:0] STACK_TOP = 2'h3;
    localparam int unsigned SYNC_N = 3;

    // Oscillator kinds.
    typedef enum logic [1:0] {
        OSC_EXT_RC = 2'b00,
        OSC_INT_FAST_RC = 2'b01,
        OSC_FAST_XTAL = 2'b10,
        OSC_SLOW_XTAL = 2'b11
    } rsfs_osc_t;

    // Sequencer states.
    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_STARTUP = 2'b01,
        ST_DELAY = 2'b10,
        ST_RUN = 2'b11
    } rsfs_state_t;

    // Last reset cause codes.
    typedef enum logic [1:0] {
        CAUSE_POR = 2'b00,
        CAUSE_PIN = 2'b01,
        CAUSE_UV = 2'b10,
        CAUSE_WDT = 2'b11
    } rsfs_cause_t;
endpackage : rsfs_pkg

// >>> design/rsfs_sync_if.sv
// Interface carrying a raw pin level into the synchroniser and the clean level back.
`timescale 1ns/100ps
`default_nettype none
interface rsfs_sync_if;
    logic raw;
    logic clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface : rsfs_sync_if
`default_nettype wire

// >>> design/rsfs_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
module rsfs_sync (
    input wire logic pclk,       // System clock.
    input wire logic presetn,    // Asynchronous reset, active low.
    rsfs_sync_if.sync sif        // Raw level in, clean level out.
);
    typedef struct packed {
        logic [2:0] stg;
        logic clean;
    } rsfs_sync_st_t;

    rsfs_sync_st_t st_r;
    rsfs_sync_st_t st_nxt;

    // Shift the level in and update the clean copy when the last two stages agree.
    always_comb begin
        st_nxt = st_r;
        st_nxt.stg = {st_r.stg[1:0], sif.raw};
        if (st_r.stg[1] == st_r.stg[2]) begin
            st_nxt.clean = st_r.stg[2];
        end
    end

    // Resets high, the idle level of an active-low pin.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '{stg: 3'h7, clean: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sif.clean = st_r.clean;
endmodule // rsfs_sync
`default_nettype wire

// >>> design/rsfs_top.sv
// Reset source and flag sequencer with an APB register slave.
//
// Summary of operation
// [R1] Undervoltage reset only when configuration enables it.
// [R2] Undervoltage qualified by persisting past filter time.
// [R3] Threshold level picked by a configuration option.
// [R4] Running watchdog time-out resets and sets flag.
// [R5] Sleeping watchdog time-out clears PC, stack, sets flag.
// [R6] Start-up wait 2 cycles RC, 128 crystal.
// [R7] Extra release delay, 50 ms, before execution.
// [R8] Time-out and power-down flags live in status.
// [R9] Power-on clears flags; pin or undervoltage keep.
// [R10] Watchdog reset sets time-out; sleeping sets both.
// [R11] Power-on disables every interrupt.
// [R12] Reset clears watchdog; counting restarts after release.
// [R13] Power-on stops timer, clears its prescaler.
// [R14] Power-on sets ports to inputs, all ones.
// [R15] Power-on points stack at its top.
// [R16] Every reset loads program counter with zero.
// [R17] Core held until sources gone and timers done.
// [R18] Reset pin active low and synchronised.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module rsfs_top #(
    parameter int unsigned RELEASE_CYC = rsfs_pkg::RELEASE_DELAY_CYC  // Release delay count.
) (
    input wire logic pclk,                // System clock, 100 MHz.
    input wire logic presetn,             // Power-on reset, asynchronous, active low.
    input wire logic psel,                // APB select.
    input wire logic penable,             // APB access phase.
    input wire logic pwrite,              // APB write.
    input wire logic [7:0] paddr,         // APB byte address.
    input wire logic [31:0] pwdata,       // APB write data.
    output logic [31:0] prdata,           // APB read data.
    output logic pready,                  // APB ready.
    output logic pslverr,                 // APB error on unmapped address.
    input wire logic ext_reset_pin_n,     // External reset pin, active low.
    input wire logic [3:0] supply_low,    // Comparator outputs, one per threshold.
    input wire logic wdt_overflow,        // Watchdog overflow pulse.
    output logic core_reset,              // Full core reset, active high.
    output logic pc_clear,                // Program counter and stack pointer clear.
    output logic wdt_clear,               // Watchdog counter clear.
    output logic timer_off,               // Timer stopped and prescaler cleared.
    output logic intr_disable,            // All core interrupts disabled.
    output logic [7:0] port_init,         // Port direction and latch reset value.
    output logic [1:0] stack_init,        // Stack pointer reset value.
    output logic irq                      // Interrupt, active high level.
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        rsfs_pkg::rsfs_state_t state;
        rsfs_pkg::rsfs_cause_t cause;
        logic [rsfs_pkg::CNT_W-1:0] cnt;
        logic [rsfs_pkg::CNT_W-1:0] uv_cnt;
        logic [31:0] ctrl;
        logic to_flag;
        logic pd_flag;
        logic [rsfs_pkg::IRQ_N-1:0] irq_stat;
        logic [rsfs_pkg::IRQ_N-1:0] irq_mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic core_reset;
        logic pc_clear;
        logic wdt_clear;
        logic timer_off;
        logic intr_disable;
        logic irq;
    } rsfs_st_t;

    rsfs_st_t st_r;
    rsfs_st_t st_nxt;
    rsfs_sync_if pin_if ();
    logic pin_low;
    logic uv_sel_low;
    logic uv_hit;
    logic sleeping;
    logic wdt_run;
    logic wdt_sleep;
    logic [rsfs_pkg::IRQ_N-1:0] ev;
    logic acc;
    logic [rsfs_pkg::CNT_W-1:0] wait_cyc;
    logic [3:0] supply_low_s;

    // ------------------------------------------------------------
    // Reset pin synchroniser
    // ------------------------------------------------------------
    assign pin_if.raw = ext_reset_pin_n;
    rsfs_sync u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .sif(pin_if)
    );
    assign pin_low = !pin_if.clean;  // R18

    // ------------------------------------------------------------
    // Supply comparator synchronisers
    // ------------------------------------------------------------
    // Comparators run off the clock, so each is inverted to idle high and synchronised.
    for (genvar gi = 0; gi < 4; gi++) begin : g_supply_sync
        rsfs_sync_if sup_if ();
        assign sup_if.raw = !supply_low[gi];
        rsfs_sync u_sup_sync (
            .pclk(pclk),
            .presetn(presetn),
            .sif(sup_if)
        );
        assign supply_low_s[gi] = !sup_if.clean;
    end

    // ------------------------------------------------------------
    // Source qualification
    // ------------------------------------------------------------
    // The threshold field picks which comparator output counts.
    assign uv_sel_low = supply_low_s[st_r.ctrl[rsfs_pkg::CTRL_UV_SEL +: 2]];  // R3
    assign uv_hit = st_r.ctrl[rsfs_pkg::CTRL_UV_EN]
        && (st_r.uv_cnt == rsfs_pkg::CNT_W'(rsfs_pkg::UV_FILTER_CYC));  // R1 R2
    assign sleeping = st_r.ctrl[rsfs_pkg::CTRL_SLEEP];
    assign wdt_run = wdt_overflow && (st_r.state == rsfs_pkg::ST_RUN) && !sleeping;  // R4
    assign wdt_sleep = wdt_overflow && (st_r.state == rsfs_pkg::ST_RUN) && sleeping;  // R5
    assign ev = {wdt_sleep, wdt_run, uv_hit, pin_low};
    assign acc = psel && penable;
    // Crystal oscillators need the long start-up wait.
    assign wait_cyc = st_r.ctrl[rsfs_pkg::CTRL_OSC + 1] ?
        rsfs_pkg::CNT_W'(rsfs_pkg::STARTUP_WAIT_XTAL) :
        rsfs_pkg::CNT_W'(rsfs_pkg::STARTUP_WAIT_RC);  // R6

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
        st_nxt.pc_clear = 1'b0;
        // Filter counter runs while the selected supply is low, saturating.
        if (!uv_sel_low || !st_r.ctrl[rsfs_pkg::CTRL_UV_EN]) begin
            st_nxt.uv_cnt = '0;  // R2
        end else if (!uv_hit) begin
            st_nxt.uv_cnt = st_r.uv_cnt + 1'b1;
        end
        // Sequencer: hold while any source stands, then start-up and delay.
        unique case (st_r.state)
            rsfs_pkg::ST_HOLD: begin
                st_nxt.cnt = '0;
                if (!pin_low && !uv_hit) begin
                    st_nxt.state = rsfs_pkg::ST_STARTUP;  // R17
                end
            end
            rsfs_pkg::ST_STARTUP: begin
                st_nxt.cnt = st_r.cnt + 1'b1;
                if (st_r.cnt + 1'b1 >= wait_cyc) begin
                    st_nxt.cnt = '0;
                    st_nxt.state = rsfs_pkg::ST_DELAY;  // R6
                end
            end
            rsfs_pkg::ST_DELAY: begin
                st_nxt.cnt = st_r.cnt + 1'b1;
                if (st_r.cnt + 1'b1 >= rsfs_pkg::CNT_W'(RELEASE_CYC)) begin
                    st_nxt.state = rsfs_pkg::ST_RUN;  // R7
                end
            end
            rsfs_pkg::ST_RUN: begin
                st_nxt.cnt = '0;
            end
        endcase
        // Sources during start-up or delay restart the hold.
        if (pin_low || uv_hit || wdt_run) begin
            st_nxt.state = rsfs_pkg::ST_HOLD;  // R17
            st_nxt.cnt = '0;
        end
        if (pin_low) begin
            st_nxt.cause = rsfs_pkg::CAUSE_PIN;  // R9
        end else if (uv_hit) begin
            st_nxt.cause = rsfs_pkg::CAUSE_UV;  // R9
        end else if (wdt_run) begin
            st_nxt.cause = rsfs_pkg::CAUSE_WDT;
        end
        // A running time-out sets its flag even when another source wins the cause.
        if (wdt_run) begin
            st_nxt.to_flag = 1'b1;  // R4 R10
        end
        // Sleeping time-out wakes the core and clears only PC and stack.
        if (wdt_sleep) begin
            st_nxt.pc_clear = 1'b1;  // R5
            st_nxt.to_flag = 1'b1;  // R10
            st_nxt.pd_flag = 1'b1;  // R10
            st_nxt.cause = rsfs_pkg::CAUSE_WDT;
            st_nxt.ctrl[rsfs_pkg::CTRL_SLEEP] = 1'b0;
        end
        // Outputs follow the next state so they stand from a flip-flop.
        st_nxt.core_reset = (st_nxt.state != rsfs_pkg::ST_RUN);  // R4 R16 R17
        st_nxt.wdt_clear = st_nxt.core_reset;  // R12
        st_nxt.timer_off = st_nxt.core_reset;  // R13
        st_nxt.intr_disable = st_nxt.core_reset;  // R11
        st_nxt.pc_clear = st_nxt.pc_clear || st_nxt.core_reset;  // R16
        // Sticky events; an interrupt status read clears them but a new event wins.
        if (acc && !st_r.pready && !pwrite && paddr == rsfs_pkg::ADDR_IRQ_STAT) begin
            st_nxt.irq_stat = '0;
        end
        st_nxt.irq_stat = st_nxt.irq_stat | ev;
        // APB slave, answering with pready in the second access cycle.
        st_nxt.prdata = '0;
        if (acc && !st_r.pready) begin
            st_nxt.pready = 1'b1;
            unique case (paddr)
                rsfs_pkg::ADDR_CTRL: begin
                    if (pwrite) begin
                        st_nxt.ctrl = pwdata & 32'h0000_003f;
                        // Entering sleep sets the power-down flag.
                        if (pwdata[rsfs_pkg::CTRL_SLEEP]) begin
                            st_nxt.pd_flag = 1'b1;  // R8
                        end
                    end else begin
                        st_nxt.prdata = st_r.ctrl;
                    end
                end
                rsfs_pkg::ADDR_STATUS: begin
                    if (pwrite) begin
                        // Software may clear the flags by writing zero; events win.
                        st_nxt.to_flag = (pwdata[rsfs_pkg::STAT_TO] && st_r.to_flag)
                            || wdt_run || wdt_sleep;  // R8
                        st_nxt.pd_flag = (pwdata[rsfs_pkg::STAT_PD] && st_r.pd_flag)
                            || wdt_sleep;  // R8
                    end else begin
                        st_nxt.prdata[rsfs_pkg::STAT_TO] = st_r.to_flag;
                        st_nxt.prdata[rsfs_pkg::STAT_PD] = st_r.pd_flag;
                        st_nxt.prdata[rsfs_pkg::STAT_CORE_RST] = st_r.core_reset;
                        st_nxt.prdata[rsfs_pkg::STAT_LAST +: 2] = st_r.cause;
                    end
                end
                rsfs_pkg::ADDR_IRQ_STAT: begin
                    st_nxt.prdata[rsfs_pkg::IRQ_N-1:0] = st_r.irq_stat;
                end
                rsfs_pkg::ADDR_IRQ_MASK: begin
                    if (pwrite) begin
                        st_nxt.irq_mask = pwdata[rsfs_pkg::IRQ_N-1:0];
                    end else begin
                        st_nxt.prdata[rsfs_pkg::IRQ_N-1:0] = st_r.irq_mask;
                    end
                end
                default: begin
                    st_nxt.pslverr = 1'b1;
                end
            endcase
        end
        st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Power-on clears both flags and holds the core in full reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '{state: rsfs_pkg::ST_HOLD, cause: rsfs_pkg::CAUSE_POR,
                cnt: '0, uv_cnt: '0, ctrl: rsfs_pkg::CTRL_RESET,
                to_flag: 1'b0, pd_flag: 1'b0,  // R9
                irq_stat: '0, irq_mask: '0, prdata: '0, pready: 1'b0, pslverr: 1'b0,
                core_reset: 1'b1, pc_clear: 1'b1, wdt_clear: 1'b1,  // R12 R16
                timer_off: 1'b1,  // R13
                intr_disable: 1'b1,  // R11
                irq: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Port and stack defaults are constant registers loaded at power-on.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_init <= rsfs_pkg::PORT_RESET;  // R14
            stack_init <= rsfs_pkg::STACK_TOP;  // R15
        end else begin
            port_init <= rsfs_pkg::PORT_RESET;
            stack_init <= rsfs_pkg::STACK_TOP;
        end
    end

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign core_reset = st_r.core_reset;
    assign pc_clear = st_r.pc_clear;
    assign wdt_clear = st_r.wdt_clear;
    assign timer_off = st_r.timer_off;
    assign intr_disable = st_r.intr_disable;
    assign irq = st_r.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_pin_seen;
        pin_low;
    endsequence
    property p_pin_reset;
        @(posedge pclk) disable iff (!presetn) s_pin_seen |=> core_reset;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin low without core reset");  // R18
    property p_uv_disabled;
        @(posedge pclk) disable iff (!presetn) !st_r.ctrl[rsfs_pkg::CTRL_UV_EN] |-> !uv_hit;
    endproperty
    a_uv_disabled: assert property (p_uv_disabled) else $error("undervoltage when disabled");  // R1
    property p_uv_short;
        @(posedge pclk) disable iff (!presetn) $rose(uv_sel_low) |-> !uv_hit [*8];
    endproperty
    a_uv_short: assert property (p_uv_short) else $error("undervoltage not filtered");  // R2
    property p_wdt_run;
        @(posedge pclk) disable iff (!presetn) wdt_run |=> core_reset && st_r.to_flag;
    endproperty
    a_wdt_run: assert property (p_wdt_run) else $error("watchdog run reset wrong");  // R4
    property p_wdt_sleep;
        @(posedge pclk) disable iff (!presetn)
            wdt_sleep && !pin_low && !uv_hit |=> pc_clear && !core_reset;
    endproperty
    a_wdt_sleep: assert property (p_wdt_sleep) else $error("sleep time-out wrong");  // R5
    property p_sleep_flags;
        @(posedge pclk) disable iff (!presetn) wdt_sleep |=> st_r.to_flag && st_r.pd_flag;
    endproperty
    a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags not set");  // R10
    property p_pin_keeps;
        @(posedge pclk) disable iff (!presetn)
            pin_low && !wdt_overflow && !acc |=> $stable(st_r.to_flag) && $stable(st_r.pd_flag);
    endproperty
    a_pin_keeps: assert property (p_pin_keeps) else $error("pin reset changed flags");  // R9
    sequence s_rc_start;
        st_r.state == rsfs_pkg::ST_HOLD
        ##1 st_r.state == rsfs_pkg::ST_STARTUP && !st_r.ctrl[rsfs_pkg::CTRL_OSC + 1]
        && !pin_low && !uv_hit;
    endsequence
    property p_startup_rc;
        @(posedge pclk) disable iff (!presetn)
            s_rc_start ##1 (!st_r.ctrl[rsfs_pkg::CTRL_OSC + 1] && !pin_low && !uv_hit)
            |-> st_r.state == rsfs_pkg::ST_STARTUP ##1 st_r.state == rsfs_pkg::ST_DELAY;
    endproperty
    a_startup_rc: assert property (p_startup_rc) else $error("start-up wait wrong");  // R6
    property p_held;
        @(posedge pclk) disable iff (!presetn) $fell(core_reset) |->
            $past(st_r.state) == rsfs_pkg::ST_DELAY
            && $past(st_r.cnt) == rsfs_pkg::CNT_W'(RELEASE_CYC - 1);
    endproperty
    a_held: assert property (p_held) else $error("core released early");  // R17
endmodule // rsfs_top
`default_nettype wire

// >>> verification/rsfs_supply_model.sv
// Model of the reset pin circuit and the supply comparators outside the block.
`timescale 1ns/100ps
`default_nettype none
module rsfs_supply_model (
    input wire logic pclk,             // System clock.
    input wire logic pin_press,        // Hold the reset pin low while high.
    input wire logic [3:0] droop,      // Supply below each threshold while high.
    output logic ext_reset_pin_n,      // Reset pin, pulled up when released.
    output logic [3:0] supply_low      // Comparator outputs.
);
    // ------------------------------------------------------------
    // Pin and comparators
    // ------------------------------------------------------------
    // The pull-up brings the pin high at the clock edge after the switch lets go.
    always @(posedge pclk) begin
        ext_reset_pin_n <= ~pin_press;
        supply_low <= droop;
    end
endmodule // rsfs_supply_model
`default_nettype wire

// >>> verification/rsfs_top_test.sv
// Self-checking testbench for the reset source and flag sequencer.
`timescale 1ns/100ps
`default_nettype none
module rsfs_top_test;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} rsfs_row_t;
    localparam int unsigned REL = 20;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, wdt_overflow = 1'b0, pin_press = 1'b0, ext_reset_pin_n;
    logic [3:0] droop = 4'h0, supply_low;
    logic core_reset, pc_clear, wdt_clear, timer_off, intr_disable, irq;
    logic [7:0] port_init;
    logic [1:0] stack_init;
    int fails = 0, n_checks = 0, cyc = 0, l1, l2, k;
    rsfs_row_t rows[6] = '{
        '{1'b0, 8'h00, 32'h0, 32'h1, 1'b0}, '{1'b1, 8'h0c, 32'hf, 32'h0, 1'b0},
        '{1'b0, 8'h0c, 32'h0, 32'hf, 1'b0}, '{1'b0, 8'h10, 32'h0, 32'h0, 1'b1},
        '{1'b1, 8'h14, 32'h5, 32'h0, 1'b1}, '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0}};

    rsfs_supply_model rsfs_supply_model_i (.pclk(pclk), .pin_press(pin_press), .droop(droop),
        .ext_reset_pin_n(ext_reset_pin_n), .supply_low(supply_low));
    rsfs_top #(.RELEASE_CYC(REL)) rsfs_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_reset_pin_n(ext_reset_pin_n),
        .supply_low(supply_low), .wdt_overflow(wdt_overflow), .core_reset(core_reset),
        .pc_clear(pc_clear), .wdt_clear(wdt_clear), .timer_off(timer_off),
        .intr_disable(intr_disable), .port_init(port_init), .stack_init(stack_init), .irq(irq));

    // ------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------
    // The clock toggles every half period; a hang ends in the report.
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer held until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // Waits for the core to be released, returning the cycles spent in reset.
    task automatic wait_run(output int n);
        n = 0;
        while (core_reset !== 1'b0 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        chk("core_reset released", core_reset, 32'h0);
    endtask
    // A watchdog overflow pulse, then the length of the reset it causes.
    task automatic wdt_hit(output int n);
        @(posedge pclk) wdt_overflow <= 1'b1;
        @(posedge pclk) wdt_overflow <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("wdt_clear", wdt_clear, 32'h1);
        wait_run(n);
    endtask
    // Holds one comparator low for a number of cycles, then reports core_reset.
    task automatic sag(input int b, input int len, input logic exp);
        @(posedge pclk) droop[b] <= 1'b1;
        repeat (len) @(posedge pclk);
        chk("uv core_reset", core_reset, {31'h0, exp});
        droop[b] <= 1'b0;
        wait_run(k);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge pclk);
        chk("core_reset", core_reset, 32'h1);
        chk("pc_clear", pc_clear, 32'h1);
        chk("intr_disable", intr_disable, 32'h1);
        chk("timer_off", timer_off, 32'h1);
        chk("port_init", port_init, 32'hff);
        chk("stack_init", stack_init, 32'h3);
        presetn <= 1'b1;
        wait_run(l1);
        chk("release delay", l1 >= REL, 32'h1);
        chk("timer_off run", timer_off, 32'h0);
        chk("intr_disable run", intr_disable, 32'h0);
        for (int i = 0; i < 6; i++) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            chk("pslverr", err, rows[i].e);
            if (!rows[i].wr && !rows[i].e) chk("prdata", rd, rows[i].x);
        end
        sag(0, 50, 1'b0);
        sag(0, 150, 1'b1);
        apb(1'b1, rsfs_pkg::ADDR_STATUS, 32'h0);
        apb(1'b0, rsfs_pkg::ADDR_STATUS, 32'h0);
        chk("status after uv", rd, 32'h20);
        apb(1'b1, rsfs_pkg::ADDR_CTRL, 32'h4);
        sag(2, 150, 1'b0);
        apb(1'b1, rsfs_pkg::ADDR_CTRL, 32'h5);
        sag(1, 150, 1'b0);
        sag(2, 150, 1'b1);
        apb(1'b1, rsfs_pkg::ADDR_CTRL, 32'h1);
        wdt_hit(l1);
        apb(1'b0, rsfs_pkg::ADDR_STATUS, 32'h0);
        chk("status after wdt", rd, 32'h31);
        apb(1'b1, rsfs_pkg::ADDR_CTRL, 32'h11);
        wdt_hit(l2);
        chk("crystal extra wait", l2 - l1, 32'd126);
        apb(1'b1, rsfs_pkg::ADDR_CTRL, 32'h21);
        apb(1'b0, rsfs_pkg::ADDR_STATUS, 32'h0);
        chk("powerdown flag", rd[1:0], 32'h3);
        @(posedge pclk) wdt_overflow <= 1'b1;
        @(posedge pclk) wdt_overflow <= 1'b0;
        k = 0;
        while (pc_clear !== 1'b1 && k < 6) begin
            @(posedge pclk);
            k++;
        end
        chk("sleep pc_clear", pc_clear, 32'h1);
        chk("sleep core_reset", core_reset, 32'h0);
        apb(1'b0, rsfs_pkg::ADDR_STATUS, 32'h0);
        chk("status after sleep wdt", rd, 32'h33);
        apb(1'b0, rsfs_pkg::ADDR_IRQ_STAT, 32'h0);
        @(posedge pclk) pin_press <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("pin core_reset", core_reset, 32'h1);
        pin_press <= 1'b0;
        wait_run(k);
        chk("irq", irq, 32'h1);
        apb(1'b0, rsfs_pkg::ADDR_IRQ_STAT, 32'h0);
        chk("irq status", rd, 32'h1);
        @(posedge pclk);
        chk("irq cleared", irq, 32'h0);
        apb(1'b0, rsfs_pkg::ADDR_STATUS, 32'h0);
        chk("status after pin", rd, 32'h13);
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        chk("intr_disable again", intr_disable, 32'h1);
        presetn <= 1'b1;
        wait_run(k);
        apb(1'b0, rsfs_pkg::ADDR_STATUS, 32'h0);
        chk("flags after power-on", rd, 32'h0);
        final_report();
    end
endmodule // rsfs_top_test
`default_nettype wire
